// ==== prr_pkg.sv ====
// Constants shared by the parameter routing and update rate block.
// Assumes a 10 MHz pclk and an APB master with 32-bit data and byte addresses.
package prr_pkg;

   // Control loop tick periods and the clock they are counted on.
   localparam int CLK_NS     = 100;
   localparam int FAST_US    = 250;
   localparam int SLOW_MS    = 4;
   localparam int FAST_CYC_I = (FAST_US * 1000) / CLK_NS;
   localparam int SLOW_CYC_I = (SLOW_MS * 1000000) / CLK_NS;
   localparam logic [11:0] FAST_CYC = 12'(FAST_CYC_I);
   localparam logic [15:0] SLOW_CYC = 16'(SLOW_CYC_I);

   // Register byte offsets, and the address pages of the pending and active pointers.
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_STATUS  = 8'h04;
   localparam logic [7:0] OFF_RATECFG = 8'h08;
   localparam logic [7:0] OFF_CLAMP   = 8'h0C;
   localparam logic [3:0] PEND_PAGE   = 4'h1;
   localparam logic [3:0] ACT_PAGE    = 4'h2;

   // Control and status bit positions.
   localparam int CTRL_RESET    = 0;
   localparam int CTRL_LOAD_LSB = 1;
   localparam int ST_TRIP       = 0;
   localparam int ST_CONFLICT   = 1;
   localparam int ST_SPD_FAST   = 2;
   localparam int ST_HARD_FAST  = 3;
   localparam int ST_TQ_FAST    = 4;
   localparam int ST_BUSY       = 5;

   // Rate configuration bit positions.
   localparam int CFG_OPEN_LOOP  = 0;
   localparam int CFG_RFC        = 1;
   localparam int CFG_VIA_AREF   = 2;
   localparam int CFG_BIPOLAR    = 3;
   localparam int CFG_MINSPD_0   = 4;
   localparam int CFG_SKIP_LSB   = 5;
   localparam int CFG_JOG        = 8;
   localparam int CFG_FF         = 9;
   localparam int CFG_HARD_AIN   = 10;
   localparam int CFG_SPD_AIN    = 11;
   localparam int CFG_TQ_AIN     = 13;
   localparam int CFG_VOLT_LSB   = 15;
   localparam int CFG_OFFZ_LSB   = 18;
   localparam int CFG_W          = 21;

   // Pointer layout: param [5:0], menu [12:8], path [17:16].
   localparam int NROUTE    = 4;
   localparam int PTR_W     = 18;
   localparam int MENU_LSB  = 8;
   localparam int PATH_LSB  = 16;
   localparam logic [4:0] MAX_MENU  = 5'h15;
   localparam logic [5:0] MAX_PARAM = 6'h33;
   localparam logic [4:0] XMENU_LO  = 5'h0F;
   localparam logic [4:0] XMENU_HI  = 5'h11;
   localparam logic [4:0] AREF_MENU = 5'h01;
   localparam logic [5:0] AREF_ONE  = 6'h24;
   localparam logic [5:0] AREF_TWO  = 6'h25;
   localparam logic [1:0] TQ_AIN_A  = 2'h2;
   localparam logic [1:0] TQ_AIN_B  = 2'h3;

   // Reset values.
   localparam logic [CFG_W-1:0] RATECFG_RST = 21'h000000;
   localparam logic [15:0]      CLAMP_RST   = 16'h7FFF;

   typedef enum logic [1:0] {PATH_GEN = 2'h0, PATH_SPEED = 2'h1, PATH_HARD = 2'h2, PATH_TORQUE = 2'h3} prr_path_e;
   typedef enum logic [1:0] {LOAD_NORMAL = 2'h0, LOAD_DEFAULTS = 2'h1, LOAD_CARD = 2'h2} prr_load_e;
   typedef enum logic {ENG_RUN, ENG_OLD} prr_eng_e;

endpackage

// ==== prr_routing.sv ====
// Parameter routing engine with destination conflict trip and update rate selection.
// Assumes an APB master on pclk and a parameter store that answers attribute lookups
// combinationally in the same cycle and accepts one destination write per cycle.
//
// Local design decisions: the register offsets and register access over APB.

// Function
// RQ1: Non-bit output to non-bit destination writes output times maximum over full scale, truncated.
// RQ2: Non-bit values routed to either analog reference use the reference clamp scaling.
// RQ3: Non-bit output to bit destination gives 0 below half maximum, else 1.
// RQ4: Duplicate destinations outside menus 15 to 17 trip; trip clear waits for resolution.
// RQ5: Bit and non-bit parameters connect either way using the matching conversion.
// RQ6: New pointer settings take effect only at a drive reset.
// RQ7: A changed destination pointer zeroes the old destination in normal operation.
// RQ8: When loading defaults, the old destination gets its default value instead.
// RQ9: When loading from a parameter card, the old destination is left untouched.
// RQ10: Speed references update every 4 ms, or every 250 us when all fast conditions hold.
// RQ11: Open-loop frequency references never use the fast update.
// RQ12: Fast speed path needs an analog reference parameter, voltage mode, zero offset input.
// RQ13: Fast speed path needs bipolar mode or zero minimum speed.
// RQ14: Fast speed path needs all three skip bands at zero.
// RQ15: Jog or velocity feed-forward enabled disables the fast speed path.
// RQ16: Hard speed reference updates at 4 ms, or 250 us under the speed limits.
// RQ17: Torque reference updates at 4 ms, fast 250 us only in rotor flux control mode.
// RQ18: Fast torque path accepts only on-board inputs 2 or 3, voltage mode, zero offset.
// RQ19: A pointer to a nonexistent parameter has no effect.
// RQ20: A pointer to a protected parameter has no effect.
// RQ21: A bit output always writes exactly 0 or 1.
// RQ22: Pointer values are limited to 0.00 through 21.51.
// RQ23: Each route is converted once per tick of its own reference path.
module prr_routing #(
   parameter logic [15:0] SLOW_CYC = prr_pkg::SLOW_CYC
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [3:0][15:0]  fn_value,
   input  wire logic [3:0][15:0]  fn_max,
   input  wire logic [3:0]        fn_is_bit,
   output logic      [12:0]       attr_addr,
   input  wire logic              attr_exists,
   input  wire logic              attr_protected,
   input  wire logic              attr_is_bit,
   input  wire logic [15:0]       attr_max,
   input  wire logic [15:0]       attr_default,
   output logic                   dst_wr_valid,
   output logic      [12:0]       dst_wr_addr,
   output logic      [15:0]       dst_wr_data,
   output logic                   destination_conflict_trip,
   output logic                   speed_fast,
   output logic                   hard_fast,
   output logic                   torque_fast
);

   typedef struct packed {
      logic [3:0][17:0]             pend;
      logic [3:0][17:0]             act;
      logic [prr_pkg::CFG_W-1:0]    cfg;
      logic [15:0]                  clamp;
      prr_pkg::prr_load_e           load;
      logic                         trip;
      logic                         rst_req;
      logic [3:0]                   due;
      prr_pkg::prr_eng_e            st;
      logic [1:0]                   idx;
      logic [11:0]                  fcnt;
      logic [15:0]                  scnt;
      logic                         ftick;
      logic                         stick;
      logic                         wr_valid;
      logic [12:0]                  wr_addr;
      logic [15:0]                  wr_data;
      logic [31:0]                  rdata;
   } prr_state_s;

   prr_state_s s_ff;
   prr_state_s nxt_s;

   logic        conflict;
   logic        common_ok;
   logic [3:0]  rt_tick;
   logic [3:0]  live;
   logic [15:0] conv;
   logic        wr_acc;
   logic        rd_setup;
   logic        addr_hit;
   logic [31:0] rd_mux;

   // A pointer write is clamped into the legal parameter range.
   function automatic logic [17:0] lim_f(input logic [31:0] w);
      logic [4:0] m;
      logic [5:0] p;
      m = w[12:8];
      p = w[5:0];
      if ({m, p} > {prr_pkg::MAX_MENU, prr_pkg::MAX_PARAM})
      begin
         m = prr_pkg::MAX_MENU; // [RQ22]
         p = prr_pkg::MAX_PARAM; // [RQ22]
      end
      return {w[17:16], 3'h0, m, 2'h0, p};
   endfunction

   function automatic logic ain_ok(input logic [1:0] sel, input logic [2:0] volt, input logic [2:0] offz);
      logic ok;
      ok = 1'b0;
      if (sel != 2'h0)
      begin
         ok = volt[sel - 2'h1] & offz[sel - 2'h1];
      end
      return ok;
   endfunction

   // Duplicate destinations are checked only outside the option and network menus.
   function automatic logic conflict_f(input logic [3:0][17:0] p);
      logic c;
      c = 1'b0;
      for (int i = 0; i < prr_pkg::NROUTE; i++)
      begin
         for (int j = i + 1; j < prr_pkg::NROUTE; j++)
         begin
            if (p[i][12:0] != 13'h0000 && p[i][12:0] == p[j][12:0] &&
                !(p[i][12:8] >= prr_pkg::XMENU_LO && p[i][12:8] <= prr_pkg::XMENU_HI))
            begin
               c = 1'b1; // [RQ4]
            end
         end
      end
      return c;
   endfunction

   // Scaling from a function output into its destination.
   function automatic logic [15:0] conv_f(input logic [15:0] fv, input logic [15:0] fm, input logic fb,
                                          input logic db, input logic [15:0] scale);
      logic [31:0] num;
      logic [31:0] q;
      logic [15:0] r;
      num = 32'(fv) * 32'(scale);
      q   = 32'h00000000;
      r   = 16'h0000;
      if (fb)
      begin
         r = {15'h0000, fv != 16'h0000}; // [RQ21] [RQ5]
      end
      else if (db)
      begin
         r = {15'h0000, {fv, 1'b0} >= {1'b0, fm}}; // [RQ3] [RQ5]
      end
      else
      begin
         if (fm != 16'h0000)
         begin
            q = num / {16'h0000, fm}; // [RQ1]
         end
         r = (q[31:16] != 16'h0000) ? 16'hFFFF : q[15:0];
      end
      return r;
   endfunction

   // Fast path qualification shared by the speed and hard speed references.
   assign common_ok = !s_ff.cfg[prr_pkg::CFG_OPEN_LOOP] && // [RQ11]
                      ain_ok(s_ff.cfg[prr_pkg::CFG_SPD_AIN +: 2], s_ff.cfg[prr_pkg::CFG_VOLT_LSB +: 3],
                             s_ff.cfg[prr_pkg::CFG_OFFZ_LSB +: 3]) && // [RQ12] [RQ16]
                      (s_ff.cfg[prr_pkg::CFG_BIPOLAR] || s_ff.cfg[prr_pkg::CFG_MINSPD_0]) && // [RQ13]
                      (s_ff.cfg[prr_pkg::CFG_SKIP_LSB +: 3] == 3'h7) && // [RQ14]
                      !s_ff.cfg[prr_pkg::CFG_JOG] && !s_ff.cfg[prr_pkg::CFG_FF]; // [RQ15]

   assign speed_fast  = common_ok && s_ff.cfg[prr_pkg::CFG_VIA_AREF]; // [RQ10] [RQ12]
   assign hard_fast   = common_ok && s_ff.cfg[prr_pkg::CFG_HARD_AIN]; // [RQ16]
   assign torque_fast = s_ff.cfg[prr_pkg::CFG_RFC] && // [RQ17]
                        (s_ff.cfg[prr_pkg::CFG_TQ_AIN +: 2] == prr_pkg::TQ_AIN_A ||
                         s_ff.cfg[prr_pkg::CFG_TQ_AIN +: 2] == prr_pkg::TQ_AIN_B) &&
                        ain_ok(s_ff.cfg[prr_pkg::CFG_TQ_AIN +: 2], s_ff.cfg[prr_pkg::CFG_VOLT_LSB +: 3],
                               s_ff.cfg[prr_pkg::CFG_OFFZ_LSB +: 3]); // [RQ18]

   assign conflict = conflict_f(s_ff.act);

   for (genvar g = 0; g < prr_pkg::NROUTE; g++)
   begin : g_route
      prr_pkg::prr_path_e path;
      assign path = prr_pkg::prr_path_e'(s_ff.act[g][17:16]);
      // Each route follows the tick of the reference path it feeds.
      assign rt_tick[g] = ((path == prr_pkg::PATH_SPEED  && speed_fast) ||
                           (path == prr_pkg::PATH_HARD   && hard_fast)  ||
                           (path == prr_pkg::PATH_TORQUE && torque_fast)) ? s_ff.ftick : s_ff.stick; // [RQ23]
      assign live[g] = s_ff.act[g][12:0] != 13'h0000;
   end

   assign attr_addr = s_ff.act[s_ff.idx][12:0];
   assign conv = conv_f(fn_value[s_ff.idx], fn_max[s_ff.idx], fn_is_bit[s_ff.idx], attr_is_bit,
                        (s_ff.act[s_ff.idx][12:8] == prr_pkg::AREF_MENU &&
                         (s_ff.act[s_ff.idx][5:0] == prr_pkg::AREF_ONE ||
                          s_ff.act[s_ff.idx][5:0] == prr_pkg::AREF_TWO)) ? s_ff.clamp : attr_max); // [RQ2]

   assign wr_acc   = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign addr_hit = (paddr[1:0] == 2'h0) && (paddr[7:4] <= prr_pkg::ACT_PAGE);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !addr_hit;

   always_comb
   begin
      rd_mux = 32'h00000000;
      if (paddr[7:4] == prr_pkg::PEND_PAGE)
      begin
         rd_mux = {14'h0000, s_ff.pend[paddr[3:2]]};
      end
      else if (paddr[7:4] == prr_pkg::ACT_PAGE)
      begin
         rd_mux = {14'h0000, s_ff.act[paddr[3:2]]};
      end
      else if (paddr == prr_pkg::OFF_CTRL)
      begin
         rd_mux = {29'h00000000, s_ff.load, s_ff.rst_req};
      end
      else if (paddr == prr_pkg::OFF_STATUS)
      begin
         rd_mux = {26'h0000000, s_ff.st == prr_pkg::ENG_OLD, torque_fast, hard_fast, speed_fast,
                   conflict, s_ff.trip};
      end
      else if (paddr == prr_pkg::OFF_RATECFG)
      begin
         rd_mux = {11'h000, s_ff.cfg};
      end
      else if (paddr == prr_pkg::OFF_CLAMP)
      begin
         rd_mux = {16'h0000, s_ff.clamp};
      end
   end

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.wr_valid = 1'b0;
      nxt_s.ftick = 1'b0;
      nxt_s.stick = 1'b0;

      // Tick generators for the two control loop rates.
      if (s_ff.fcnt == prr_pkg::FAST_CYC - 12'h001)
      begin
         nxt_s.fcnt  = 12'h000;
         nxt_s.ftick = 1'b1;
      end
      else
      begin
         nxt_s.fcnt = s_ff.fcnt + 12'h001;
      end
      if (s_ff.scnt == SLOW_CYC - 16'h0001)
      begin
         nxt_s.scnt  = 16'h0000;
         nxt_s.stick = 1'b1;
      end
      else
      begin
         nxt_s.scnt = s_ff.scnt + 16'h0001;
      end

      unique case (s_ff.st)
         prr_pkg::ENG_RUN:
         begin
            if (s_ff.due[s_ff.idx])
            begin
               nxt_s.due[s_ff.idx] = 1'b0;
               if (live[s_ff.idx] && attr_exists && !attr_protected) // [RQ19] [RQ20]
               begin
                  nxt_s.wr_valid = 1'b1; // [RQ23]
                  nxt_s.wr_addr  = attr_addr;
                  nxt_s.wr_data  = conv;
               end
            end
            if (s_ff.rst_req)
            begin
               nxt_s.st  = prr_pkg::ENG_OLD;
               nxt_s.idx = 2'h0;
            end
            else
            begin
               nxt_s.idx = s_ff.idx + 2'h1;
            end
         end
         prr_pkg::ENG_OLD:
         begin
            if (s_ff.pend[s_ff.idx][12:0] != s_ff.act[s_ff.idx][12:0] && live[s_ff.idx] &&
                attr_exists && !attr_protected && s_ff.load != prr_pkg::LOAD_CARD) // [RQ9] [RQ19] [RQ20]
            begin
               nxt_s.wr_valid = 1'b1;
               nxt_s.wr_addr  = attr_addr;
               nxt_s.wr_data  = (s_ff.load == prr_pkg::LOAD_DEFAULTS) ? attr_default : 16'h0000; // [RQ7] [RQ8]
            end
            nxt_s.idx = s_ff.idx + 2'h1;
            if (s_ff.idx == 2'h3)
            begin
               nxt_s.act     = s_ff.pend; // [RQ6]
               nxt_s.st      = prr_pkg::ENG_RUN;
               nxt_s.rst_req = 1'b0;
            end
         end
      endcase

      // Ticks are set after the scan clears them so that none is lost.
      nxt_s.due = nxt_s.due | rt_tick; // [RQ23]

      // The trip may only be cleared once the duplicate route is gone.
      if (wr_acc && paddr == prr_pkg::OFF_STATUS && pwdata[prr_pkg::ST_TRIP] && !conflict)
      begin
         nxt_s.trip = 1'b0; // [RQ4]
      end
      if (conflict)
      begin
         nxt_s.trip = 1'b1; // [RQ4]
      end

      if (wr_acc && addr_hit)
      begin
         if (paddr[7:4] == prr_pkg::PEND_PAGE)
         begin
            nxt_s.pend[paddr[3:2]] = lim_f(pwdata); // [RQ22]
         end
         else if (paddr == prr_pkg::OFF_CTRL)
         begin
            nxt_s.load = prr_pkg::prr_load_e'(pwdata[prr_pkg::CTRL_LOAD_LSB +: 2]);
            if (pwdata[prr_pkg::CTRL_RESET])
            begin
               nxt_s.rst_req = 1'b1; // [RQ6]
            end
         end
         else if (paddr == prr_pkg::OFF_RATECFG)
         begin
            nxt_s.cfg = pwdata[prr_pkg::CFG_W-1:0];
         end
         else if (paddr == prr_pkg::OFF_CLAMP)
         begin
            nxt_s.clamp = pwdata[15:0];
         end
      end

      // Read data is captured in the setup phase so the access can complete without wait states.
      if (rd_setup)
      begin
         nxt_s.rdata = rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff       <= '0;
         s_ff.cfg   <= prr_pkg::RATECFG_RST;
         s_ff.clamp <= prr_pkg::CLAMP_RST;
         s_ff.load  <= prr_pkg::LOAD_NORMAL;
         s_ff.st    <= prr_pkg::ENG_RUN;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign prdata                    = s_ff.rdata;
   assign dst_wr_valid              = s_ff.wr_valid;
   assign dst_wr_addr               = s_ff.wr_addr;
   assign dst_wr_data               = s_ff.wr_data;
   assign destination_conflict_trip = s_ff.trip;

endmodule

// ==== prr_routing_monitor.sv ====
// Concurrent checks on the ports of the parameter routing block.
// Assumes one pclk domain with presetn as its asynchronous active low reset.
module prr_routing_monitor #(
   parameter logic [15:0] SLOW_CYC = prr_pkg::SLOW_CYC
)(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [12:0] attr_addr,
   input wire logic        attr_exists,
   input wire logic        attr_protected,
   input wire logic        attr_is_bit,
   input wire logic        dst_wr_valid,
   input wire logic [12:0] dst_wr_addr,
   input wire logic [15:0] dst_wr_data,
   input wire logic        destination_conflict_trip,
   input wire logic        speed_fast,
   input wire logic        hard_fast,
   input wire logic        torque_fast
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable && pwrite;
   property p_exists;
      dst_wr_valid |-> $past(attr_exists);
   endproperty
   a_exists: assert property (p_exists) else $error("write to a missing parameter");
   property p_prot;
      dst_wr_valid |-> !$past(attr_protected);
   endproperty
   a_prot: assert property (p_prot) else $error("write to a protected parameter");
   property p_addr;
      dst_wr_valid |-> dst_wr_addr == $past(attr_addr);
   endproperty
   a_addr: assert property (p_addr) else $error("write address differs from lookup");
   property p_bit;
      dst_wr_valid && $past(attr_is_bit) |-> dst_wr_data <= 16'h0001;
   endproperty
   a_bit: assert property (p_bit) else $error("bit destination got a wide value");
   property p_range;
      dst_wr_valid |-> {dst_wr_addr[12:8], dst_wr_addr[5:0]} <= {5'h15, 6'h33};
   endproperty
   a_range: assert property (p_range) else $error("destination beyond the pointer range");
   property p_trip;
      $past(destination_conflict_trip) && !destination_conflict_trip |-> $past(acc && paddr == 8'h04 && pwdata[0]);
   endproperty
   a_trip: assert property (p_trip) else $error("trip dropped without a clear");
   property p_fast;
      $changed({torque_fast, hard_fast, speed_fast}) |-> $past(acc && paddr == 8'h08);
   endproperty
   a_fast: assert property (p_fast) else $error("rate flag moved without a config write");
   property p_hard;
      acc && paddr == 8'h08 && !pwdata[10] |=> !hard_fast;
   endproperty
   a_hard: assert property (p_hard) else $error("hard fast path without its analog source");
   c_wr: cover property (dst_wr_valid);
   c_trip: cover property ($rose(destination_conflict_trip));
   c_spd: cover property ($rose(speed_fast));
   c_tq: cover property ($rose(torque_fast));
endmodule
bind prr_routing prr_routing_monitor #(.SLOW_CYC(SLOW_CYC)) u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .attr_addr(attr_addr), .attr_exists(attr_exists), .attr_protected(attr_protected),
   .attr_is_bit(attr_is_bit), .dst_wr_valid(dst_wr_valid), .dst_wr_addr(dst_wr_addr),
   .dst_wr_data(dst_wr_data), .destination_conflict_trip(destination_conflict_trip),
   .speed_fast(speed_fast), .hard_fast(hard_fast), .torque_fast(torque_fast));

// ==== tb_parameter_routing_and_update_rate.sv ====
// Directed bench for the routing block with APB tasks and a parameter store model.
// Assumes a shortened slow tick so that every test fits in a few thousand cycles.
module tb_parameter_routing_and_update_rate;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] SLOW = 16'h00C8;
   localparam logic [20:0] CFG [15] = '{21'h0488EC, 21'h048CEC, 21'h0488ED, 21'h0488E8, 21'h0488E4,
      21'h0488F4, 21'h0488CC, 21'h0489EC, 21'h048AEC, 21'h0408EC, 21'h0088EC, 21'h094002, 21'h126002,
      21'h04A002, 21'h094000};
   localparam logic [2:0] EXP [15] = '{3'h1, 3'h3, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
      3'h4, 3'h4, 3'h0, 3'h0};
   logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata, rd_data;
   logic [3:0][15:0] fn_value = '0, fn_max = {4{16'h0400}};
   logic [3:0]       fn_is_bit = 4'h0;
   logic [12:0]      attr_addr, dst_wr_addr, last_a;
   logic [15:0]      attr_max, attr_default, dst_wr_data, last_d;
   logic             pready, pslverr, rd_err, attr_exists, attr_protected, attr_is_bit, dst_wr_valid;
   logic             trip, spd_f, hard_f, tq_f;
   int               num_errors = 0, checked = 0, wr_cnt = 0, cyc = 0, last_cyc = 0;
   // The store answers from the address alone; defaults differ so that a default write is visible.
   assign attr_exists    = attr_addr[5:0] != 6'h32;
   assign attr_protected = attr_addr[5:0] == 6'h31;
   assign attr_is_bit    = attr_addr[5:0] inside {[6'h28:6'h30]};
   assign attr_max       = 16'h03E8;
   assign attr_default   = attr_is_bit ? 16'h0001 : 16'h0055;
   always #50 pclk = ~pclk;
   prr_routing #(.SLOW_CYC(SLOW)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fn_value(fn_value), .fn_max(fn_max), .fn_is_bit(fn_is_bit), .attr_addr(attr_addr),
      .attr_exists(attr_exists), .attr_protected(attr_protected), .attr_is_bit(attr_is_bit),
      .attr_max(attr_max), .attr_default(attr_default), .dst_wr_valid(dst_wr_valid),
      .dst_wr_addr(dst_wr_addr), .dst_wr_data(dst_wr_data), .destination_conflict_trip(trip),
      .speed_fast(spd_f), .hard_fast(hard_f), .torque_fast(tq_f));
   always @(posedge pclk)
   begin
      cyc++;
      if (dst_wr_valid === 1'b1)
      begin
         wr_cnt++;
         last_a   = dst_wr_addr;
         last_d   = dst_wr_data;
         last_cyc = cyc;
      end
   end
   task automatic finish_test();
      $display("Checks %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk({rd_err, rd_data}, {1'b0, exp});
   endtask
   function automatic logic [31:0] pv(input logic [4:0] m, input logic [5:0] p, input logic [1:0] pa);
      return {14'h0, pa, 3'h0, m, 2'h0, p};
   endfunction
   task automatic setp(input int i, input logic [4:0] m, input logic [5:0] p, input logic [1:0] pa);
      apb(1'b1, 8'(8'h10 + 4 * i), pv(m, p, pa));
   endtask
   task automatic setfn(input logic [15:0] v, input logic b);
      @(posedge pclk);
      fn_value[0]  <= v;
      fn_is_bit[0] <= b;
   endtask
   task automatic wait_wr(input int n, output logic got);
      int c0;
      c0  = wr_cnt;
      got = 1'b0;
      repeat (n)
      begin
         @(negedge pclk);
         if (wr_cnt != c0)
         begin
            got = 1'b1;
            break;
         end
      end
   endtask
   task automatic chk_wr(input logic [12:0] a, input logic [15:0] d);
      logic got;
      wait_wr(300, got);
      checked++;
      if (got !== 1'b1 || last_a !== a || last_d !== d)
      begin
         num_errors++;
         $display("ERROR at %0t: write %h=%h, expected %h=%h", $time, last_a, last_d, a, d);
      end
   endtask
   task automatic drv_rst(input logic [1:0] mode);
      apb(1'b1, prr_pkg::OFF_CTRL, {29'h0, mode, 1'b1});
      repeat (20)
      begin
         apb(1'b0, prr_pkg::OFF_STATUS, 32'h0);
         if (rd_data[prr_pkg::ST_BUSY] === 1'b0)
            break;
      end
      chk(rd_data[prr_pkg::ST_BUSY], 1'b0);
   endtask
   // Syncs to a route write first, so no tick write can fall into the reset window.
   task automatic old_test(input logic [1:0] mode, input logic [12:0] olda, input int n, input logic [15:0] d);
      logic got;
      int   c0;
      wait_wr(300, got);
      chk({got, last_a}, {1'b1, olda});
      c0 = wr_cnt;
      drv_rst(mode);
      chk(32'(wr_cnt - c0), 32'(n));
      if (n > 0)
         chk({last_a, last_d}, {olda, d});
   endtask
   initial
   begin
      logic got;
      int   t;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(prr_pkg::OFF_STATUS, 32'h0);
      rd(prr_pkg::OFF_RATECFG, 32'h0);
      rd(prr_pkg::OFF_CLAMP, 32'h7FFF);
      apb(1'b0, 8'h30, 32'h0);
      chk({rd_err, rd_data}, {1'b1, 32'h0});
      setp(0, 5'h1F, 6'h3F, 2'h0);
      rd(8'h10, pv(5'h15, 6'h33, 2'h0));
      $display("Test registers done");
      setfn(16'h012C, 1'b0);
      setp(0, 5'h02, 6'h05, 2'h0);
      rd(8'h20, 32'h0);
      drv_rst(prr_pkg::LOAD_NORMAL);
      rd(8'h20, pv(5'h02, 6'h05, 2'h0));
      chk_wr({5'h02, 2'h0, 6'h05}, 16'h0124);
      t = last_cyc;
      chk_wr({5'h02, 2'h0, 6'h05}, 16'h0124);
      chk(32'(last_cyc - t), 32'(SLOW));
      setfn(16'h01FF, 1'b0);
      setp(0, 5'h02, 6'h28, 2'h0);
      old_test(prr_pkg::LOAD_NORMAL, {5'h02, 2'h0, 6'h05}, 1, 16'h0000);
      chk_wr({5'h02, 2'h0, 6'h28}, 16'h0000);
      setfn(16'h0200, 1'b0);
      chk_wr({5'h02, 2'h0, 6'h28}, 16'h0001);
      setfn(16'h012C, 1'b0);
      apb(1'b1, prr_pkg::OFF_CLAMP, 32'h0800);
      setp(0, 5'h01, 6'h24, 2'h0);
      old_test(prr_pkg::LOAD_DEFAULTS, {5'h02, 2'h0, 6'h28}, 1, 16'h0001);
      chk_wr({5'h01, 2'h0, 6'h24}, 16'h0258);
      setfn(16'h0007, 1'b1);
      chk_wr({5'h01, 2'h0, 6'h24}, 16'h0001);
      $display("Test conversions done");
      setp(0, 5'h02, 6'h32, 2'h0);
      old_test(prr_pkg::LOAD_CARD, {5'h01, 2'h0, 6'h24}, 0, 16'h0000);
      wait_wr(450, got);
      chk(got, 1'b0);
      setp(0, 5'h02, 6'h31, 2'h0);
      drv_rst(prr_pkg::LOAD_NORMAL);
      wait_wr(450, got);
      chk(got, 1'b0);
      $display("Test discards done");
      setp(0, 5'h03, 6'h05, 2'h0);
      setp(1, 5'h03, 6'h05, 2'h0);
      drv_rst(prr_pkg::LOAD_NORMAL);
      apb(1'b1, prr_pkg::OFF_STATUS, 32'h1);
      rd(prr_pkg::OFF_STATUS, 32'h3);
      setp(0, 5'h11, 6'h05, 2'h0);
      setp(1, 5'h11, 6'h05, 2'h0);
      drv_rst(prr_pkg::LOAD_NORMAL);
      apb(1'b1, prr_pkg::OFF_STATUS, 32'h1);
      rd(prr_pkg::OFF_STATUS, 32'h0);
      chk(trip, 1'b0);
      $display("Test conflict done");
      for (int i = 0; i < 15; i++)
      begin
         apb(1'b1, prr_pkg::OFF_RATECFG, {11'h0, CFG[i]});
         apb(1'b0, prr_pkg::OFF_STATUS, 32'h0);
         chk({rd_data[4:2], tq_f, hard_f, spd_f}, {EXP[i], EXP[i]});
      end
      apb(1'b1, prr_pkg::OFF_RATECFG, 32'h0488EC);
      setp(0, 5'h00, 6'h00, 2'h0);
      setp(1, 5'h00, 6'h00, 2'h0);
      setp(2, 5'h04, 6'h05, 2'h1);
      drv_rst(prr_pkg::LOAD_NORMAL);
      wait_wr(3000, got);
      wait_wr(3000, got);
      t = last_cyc;
      wait_wr(3000, got);
      chk(32'(last_cyc - t), 32'(prr_pkg::FAST_CYC_I));
      $display("Test rates done");
      finish_test();
   end
   initial
   begin
      repeat (30000) @(posedge pclk);
      num_errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      finish_test();
   end
endmodule
